// File: verilog/mpc_config_map.sv
// Interface RAM word map and configuration word of the modem data pump
//
// Notes on behaviour
// (R01) Originate-select bit 14 set means originating modem, clear means answer mode.
// (R02) Host writes originate-select no later than the write setting the mode field.
// (R03) Error bit 13 is set on any internal fault, such as invalid mode code.
// (R04) Host should reset the device after seeing the error bit set.
// (R05) Manual-handshake bit 10 hands the 2400 bps handshake sequence to the host.
// (R06) Writing one to soft-reset bit 8 starts a software reset in any mode.
// (R07) Device clears soft-reset bit itself when the software reset has finished.
// (R08) Host always writes zero to unused bits 15 and 7.
// (R09) Configuration word at address 01ff is zero after reset.
// (R10) Host updates words by read-modify-write, preserving undocumented bits.
// (R11) Each access takes up to 105 us; request flag clears on completion.
// (R12) Mode zero selects idle standby, not a low-power sleep state.
// (R13) Reserved bits 12, 11 and 9 keep the written value and do nothing.
`timescale 1ns/1ps
module mpc_config_map
    import mpc_pkg::*;
#(
    parameter int ACC_CYCLES  = ACCESS_CYCLES,  // Indirect access latency
    parameter int SRST_CYCLES = SOFT_RESET_REQUEST_CYCLES   // Soft reset duration
) (
    input  wire logic              sys_clk,                 // System clock
    input  wire logic              reset,                   // Async reset, active high
    input  wire logic              access_start,            // Request pulse
    input  wire mpc_req_t          access_req,              // Address, direction, data
    output logic [DATA_W-1:0]      access_rdata,            // Read data of last read
    output logic                   ram_request_flag,        // Access in progress
    input  wire logic              internal_fault,          // Fault seen by pump core
    output logic                   originate_select,        // Originating modem
    output logic                   manual_handshake_enable, // Host-driven handshake
    output logic [MODE_W-1:0]      operating_mode,          // Selected mode
    output logic                   standby_idle,            // Idle standby running
    output logic                   pump_error,              // Error flag
    output logic                   soft_reset_request,      // Soft reset bit
    output logic                   pump_in_reset            // Soft reset in progress
);

    localparam int ACC_W  = $clog2(ACC_CYCLES + 1);
    localparam int SRST_W = $clog2(SRST_CYCLES + 1);

    typedef struct packed {
        mpc_phase_t                    phase;
        mpc_req_t                      req;
        logic [DATA_W-1:0]             rdata;
        logic [NWORDS-1:0][DATA_W-1:0] words;
        logic                          srst_run;
    } map_state_t;

    map_state_t        state_reg;
    map_state_t        state_next;
    logic              acc_start;
    logic              acc_done;
    logic              srst_start;
    logic              srst_done;
    logic              fault;
    logic [DATA_W-1:0] cfg;
    logic [DATA_W-1:0] cfg_wr;
    mpc_hit_t          hit;

    assign cfg = state_reg.words[CFG_INDEX];

    // Access latency timer; the flag stays up for the whole run
    mpc_delay #(
        .CNT_W      (ACC_W)
    ) u_access_delay (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .start      (acc_start),
        .load_count (ACC_W'(ACC_CYCLES)),
        .running    (),
        .done       (acc_done)
    );

    // Soft reset timer
    mpc_delay #(
        .CNT_W      (SRST_W)
    ) u_soft_reset_delay (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .start      (srst_start),
        .load_count (SRST_W'(SRST_CYCLES)),
        .running    (),
        .done       (srst_done)
    );

    // Internal faults include an illegal mode code
    assign fault = internal_fault || !mpc_mode_valid(cfg[MODE_W-1:0]); // see (R03)

    // Configuration word as written by the host
    always_comb begin
        cfg_wr                = state_reg.req.wdata & ~CFG_UNUSED_MASK;  // Unused bits read zero
        cfg_wr[CFG_ERR_BIT]   = cfg[CFG_ERR_BIT];                         // Host cannot forge it
        cfg_wr[CFG_SRST_BIT]  = cfg[CFG_SRST_BIT] | state_reg.req.wdata[CFG_SRST_BIT]; // see (R06)
    end

    // Access sequencing, soft reset and error flag
    always_comb begin
        state_next = state_reg;
        acc_start  = 1'b0;
        srst_start = 1'b0;
        hit        = mpc_decode(state_reg.req.addr);
        unique case (state_reg.phase)
            ACC_IDLE: begin
                // New requests only taken while idle; busy-time requests are dropped
                if (access_start) begin // see (R11)
                    state_next.req   = access_req;
                    state_next.phase = ACC_BUSY;
                    acc_start        = 1'b1;
                end
            end
            ACC_BUSY: begin
                if (acc_done) begin
                    state_next.phase = ACC_IDLE; // see (R11)
                    if (state_reg.req.write) begin
                        if (hit.hit && hit.idx == CFG_INDEX) begin
                            state_next.words[CFG_INDEX] = cfg_wr; // see (R01) (R05) (R13)
                        end else if (hit.hit) begin
                            state_next.words[hit.idx] = state_reg.req.wdata;
                        end
                    end else begin
                        // Unmapped reads return zero
                        state_next.rdata = hit.hit ? state_reg.words[hit.idx] : WORD_RESET;
                    end
                end
            end
        endcase
        // Start the soft reset once the bit lands
        if (state_next.words[CFG_INDEX][CFG_SRST_BIT] && !state_reg.srst_run) begin
            srst_start          = 1'b1; // see (R06)
            state_next.srst_run = 1'b1;
        end
        // Completion returns the word to its reset value and drops the bit
        if (srst_done) begin
            state_next.words[CFG_INDEX] = CFG_RESET; // see (R07)
            state_next.srst_run         = 1'b0;
        end
        // Set wins over the soft reset clear so no fault is lost
        if (fault) begin
            state_next.words[CFG_INDEX][CFG_ERR_BIT] = 1'b1; // see (R03)
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg                  <= '0;
            state_reg.phase            <= ACC_IDLE;
            state_reg.words[CFG_INDEX] <= CFG_RESET; // see (R09)
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the stored state
    assign access_rdata            = state_reg.rdata;
    assign ram_request_flag        = state_reg.phase == ACC_BUSY;
    assign originate_select        = cfg[CFG_ORG_BIT];  // see (R01)
    assign manual_handshake_enable = cfg[CFG_MCU_BIT];  // see (R05)
    assign operating_mode          = cfg[MODE_W-1:0];
    assign pump_error              = cfg[CFG_ERR_BIT];
    assign soft_reset_request      = cfg[CFG_SRST_BIT];
    assign pump_in_reset           = state_reg.srst_run;
    // Mode zero is idle standby; no sleep state is entered from here
    assign standby_idle = operating_mode == MODE_STANDBY && !state_reg.srst_run; // see (R12)

    // ---------------- Checks ----------------

    // Bound follows the instance's own soft reset length, not the package default
    localparam int SRST_WAIT = SRST_CYCLES + 2;

    logic             cfg_write_done;
    logic             seen_clk;
    logic [ACC_W:0]   busy_cnt;

    assign cfg_write_done = acc_done && state_reg.req.write &&
                            state_reg.req.addr == ADDR_PUMP_CONFIGURATION;

    // Marks the first clock after reset release
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            seen_clk <= 1'b0;
        end else begin
            seen_clk <= 1'b1;
        end
    end

    // Length of the current access
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            busy_cnt <= '0;
        end else if (ram_request_flag) begin
            busy_cnt <= busy_cnt + (ACC_W + 1)'(1);
        end else begin
            busy_cnt <= '0;
        end
    end

    a_org_from_write: assert property (@(posedge sys_clk) disable iff (reset) // see (R01)
        cfg_write_done && !srst_done |=> originate_select == $past(state_reg.req.wdata[CFG_ORG_BIT]))
        else $error("originate select does not follow config write");

    a_error_on_fault: assert property (@(posedge sys_clk) disable iff (reset) // see (R03)
        internal_fault |=> pump_error)
        else $error("error flag not set after internal fault");

    a_error_sticky: assert property (@(posedge sys_clk) disable iff (reset) // see (R03)
        pump_error && !srst_done |=> pump_error)
        else $error("error flag dropped without soft reset");

    a_mcu_from_write: assert property (@(posedge sys_clk) disable iff (reset) // see (R05)
        cfg_write_done && !srst_done
            |=> manual_handshake_enable == $past(state_reg.req.wdata[CFG_MCU_BIT]))
        else $error("manual handshake bit does not follow config write");

    a_soft_reset_request_starts: assert property (@(posedge sys_clk) disable iff (reset) // see (R06)
        cfg_write_done && state_reg.req.wdata[CFG_SRST_BIT] |=> soft_reset_request ##1 pump_in_reset)
        else $error("soft reset did not start after write");

    a_soft_reset_request_clears: assert property (@(posedge sys_clk) disable iff (reset) // see (R07)
        $rose(pump_in_reset) |-> ##[1:SRST_WAIT] (!soft_reset_request && !pump_in_reset))
        else $error("soft reset bit not cleared in time");

    a_cfg_reset_zero: assert property (@(posedge sys_clk) disable iff (reset) // see (R09)
        !seen_clk |-> cfg == CFG_RESET)
        else $error("config word not zero after reset");

    a_access_bound: assert property (@(posedge sys_clk) disable iff (reset) // see (R11)
        busy_cnt <= (ACC_W + 1)'(ACC_CYCLES))
        else $error("access held longer than its latency");

    a_busy_holds_req: assert property (@(posedge sys_clk) disable iff (reset) // see (R11)
        ram_request_flag && !acc_done |=> ram_request_flag && $stable(state_reg.req))
        else $error("request changed or flag dropped mid access");

    a_standby_mode: assert property (@(posedge sys_clk) disable iff (reset) // see (R12)
        cfg_write_done && !srst_done && state_reg.req.wdata[MODE_W-1:0] == MODE_STANDBY
            && !state_reg.req.wdata[CFG_SRST_BIT] && !state_reg.srst_run |=> standby_idle)
        else $error("mode zero did not give standby");

    a_reserved_kept: assert property (@(posedge sys_clk) disable iff (reset) // see (R13)
        cfg_write_done && !srst_done |=> cfg[12:11] == $past(state_reg.req.wdata[12:11])
            && cfg[9] == $past(state_reg.req.wdata[9]))
        else $error("reserved config bits not kept");

endmodule : mpc_config_map

// File: verilog/mpc_pkg.sv
// Shared constants, word map and types for the modem pump configuration word map
package mpc_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS  = 20;
    localparam int SYS_CLK_MHZ    = 50;
    localparam int ACCESS_TIME_US = 105;
    localparam int ACCESS_CYCLES  = ACCESS_TIME_US * SYS_CLK_MHZ;
    localparam int SOFT_RESET_REQUEST_TIME_NS = 1000;
    localparam int SOFT_RESET_REQUEST_CYCLES  = (SOFT_RESET_REQUEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Word geometry
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int IDX_W  = 7;
    localparam int NWORDS = 80;

    // Interface RAM word addresses
    localparam logic [8:0] ADDR_DISCRETE_TONE_DETECT_STATUS  = 9'h000;
    localparam logic [8:0] ADDR_TONE_DETECT_THRESHOLD        = 9'h003;
    localparam logic [8:0] ADDR_TONE_DETECTOR_LEVELS         = 9'h026;
    localparam logic [8:0] ADDR_BIQUAD_ON_POINT              = 9'h051;
    localparam logic [8:0] ADDR_BIQUAD_OFF_POINT             = 9'h052;
    localparam logic [8:0] ADDR_EYE_QUALITY_LEVEL            = 9'h092;
    localparam logic [8:0] ADDR_TONE_DETECTOR_COEFFICIENTS   = 9'h145;
    localparam logic [8:0] ADDR_BIQUAD_FIRST_COEFFICIENTS    = 9'h155;
    localparam logic [8:0] ADDR_BIQUAD_SECOND_COEFFICIENTS   = 9'h15f;
    localparam logic [8:0] ADDR_MODEM_TRANSMIT_LEVEL         = 9'h185;
    localparam logic [8:0] ADDR_DIAL_ON_COUNT                = 9'h18c;
    localparam logic [8:0] ADDR_DIAL_OFF_COUNT               = 9'h18d;
    localparam logic [8:0] ADDR_DIAL_INTERPULSE_COUNT        = 9'h18e;
    localparam logic [8:0] ADDR_TONE_GENERATOR_FIRST         = 9'h191;
    localparam logic [8:0] ADDR_TONE_GENERATOR_SECOND        = 9'h196;
    localparam logic [8:0] ADDR_DIALTONE_LOW_BAND_LEVEL      = 9'h1a0;
    localparam logic [8:0] ADDR_DIALTONE_HIGH_BAND_LEVEL     = 9'h1a1;
    localparam logic [8:0] ADDR_BAND_REJECT_COEFFICIENTS     = 9'h1a2;
    localparam logic [8:0] ADDR_CONNECTION_SPEED             = 9'h1f0;
    localparam logic [8:0] ADDR_CARRIER_DETECT_ON_THRESHOLD  = 9'h1f4;
    localparam logic [8:0] ADDR_CARRIER_DETECT_OFF_THRESHOLD = 9'h1f5;
    localparam logic [8:0] ADDR_MSE_MAX_THRESHOLD            = 9'h1f6;
    localparam logic [8:0] ADDR_MODEM_CONTROL_STATUS         = 9'h1f7;
    localparam logic [8:0] ADDR_PUMP_MISC_CONTROLS           = 9'h1fa;
    localparam logic [8:0] ADDR_TONE_CONTROL_STATUS          = 9'h1fc;
    localparam logic [8:0] ADDR_BUFFER_CONTROL               = 9'h1fd;
    localparam logic [8:0] ADDR_TRAINING_CONTROL             = 9'h1fe;
    localparam logic [8:0] ADDR_PUMP_CONFIGURATION           = 9'h1ff;

    // Contiguous runs of words; storage index follows region order
    localparam int N_REGIONS = 15;
    localparam logic [N_REGIONS-1:0][8:0] REGION_BASE = {
        ADDR_TONE_CONTROL_STATUS, ADDR_PUMP_MISC_CONTROLS,
        ADDR_CARRIER_DETECT_ON_THRESHOLD, ADDR_CONNECTION_SPEED,
        ADDR_DIALTONE_LOW_BAND_LEVEL, ADDR_TONE_GENERATOR_SECOND,
        ADDR_TONE_GENERATOR_FIRST, ADDR_DIAL_ON_COUNT, ADDR_MODEM_TRANSMIT_LEVEL,
        ADDR_TONE_DETECTOR_COEFFICIENTS, ADDR_EYE_QUALITY_LEVEL, ADDR_BIQUAD_ON_POINT,
        ADDR_TONE_DETECTOR_LEVELS, ADDR_TONE_DETECT_THRESHOLD,
        ADDR_DISCRETE_TONE_DETECT_STATUS};
    localparam logic [N_REGIONS-1:0][8:0] REGION_LEN = {
        9'h004, 9'h001, 9'h004, 9'h001, 9'h007, 9'h001, 9'h001, 9'h003,
        9'h001, 9'h024, 9'h001, 9'h002, 9'h010, 9'h001, 9'h001};
    localparam logic [IDX_W-1:0] CFG_INDEX = 7'h4f;

    // Configuration word fields
    localparam int CFG_ORG_BIT   = 14;
    localparam int CFG_ERR_BIT   = 13;
    localparam int CFG_MCU_BIT   = 10;
    localparam int CFG_SRST_BIT  = 8;
    localparam int MODE_W        = 7;
    localparam logic [15:0] CFG_RESET       = 16'h0000;
    localparam logic [15:0] CFG_UNUSED_MASK = 16'h8080;
    localparam logic [15:0] WORD_RESET      = 16'h0000;

    // Operating-mode codes
    localparam logic [6:0] MODE_STANDBY     = 7'h00;
    localparam logic [6:0] MODE_TONE_TX     = 7'h01;
    localparam logic [6:0] MODE_TONE_DETECT = 7'h02;
    localparam logic [6:0] MODE_DIAL        = 7'h03;
    localparam logic [6:0] MODE_TONE_TXRX   = 7'h04;
    localparam logic [6:0] MODE_QAM_2400    = 7'h08;
    localparam logic [6:0] MODE_DPSK_1200   = 7'h09;
    localparam logic [6:0] MODE_DPSK_ALT    = 7'h0b;
    localparam logic [6:0] MODE_FSK_300     = 7'h10;
    localparam logic [6:0] MODE_FSK_ALT     = 7'h11;
    localparam logic [6:0] MODE_SPLIT_1200  = 7'h13;

    typedef enum logic {ACC_IDLE, ACC_BUSY} mpc_phase_t;

    // One indirect access request
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mpc_req_t;

    typedef struct packed {
        logic             hit;
        logic [IDX_W-1:0] idx;
    } mpc_hit_t;

    // Map a word address onto a storage index
    function automatic mpc_hit_t mpc_decode(input logic [ADDR_W-1:0] addr);
        mpc_hit_t         r;
        logic [IDX_W-1:0] base_idx;
        r        = '0;
        base_idx = '0;
        for (int i = 0; i < N_REGIONS; i++) begin
            if (addr >= REGION_BASE[i] &&
                10'(addr) < 10'(REGION_BASE[i]) + 10'(REGION_LEN[i])) begin
                r.hit = 1'b1;
                r.idx = base_idx + IDX_W'(addr - REGION_BASE[i]);
            end
            base_idx = base_idx + REGION_LEN[i][IDX_W-1:0];
        end
        return r;
    endfunction : mpc_decode

    // Only listed operating modes are legal
    function automatic logic mpc_mode_valid(input logic [MODE_W-1:0] mode);
        case (mode)
            MODE_STANDBY, MODE_TONE_TX, MODE_TONE_DETECT, MODE_DIAL, MODE_TONE_TXRX,
            MODE_QAM_2400, MODE_DPSK_1200, MODE_DPSK_ALT, MODE_FSK_300, MODE_FSK_ALT,
            MODE_SPLIT_1200: return 1'b1;
            default:         return 1'b0;
        endcase
    endfunction : mpc_mode_valid

endpackage : mpc_pkg

// File: verilog/mpc_delay.sv
// Down-counting delay used for access latency and soft reset duration
`timescale 1ns/1ps
module mpc_delay
    import mpc_pkg::*;
#(
    parameter int CNT_W = 13
) (
    input  wire logic             sys_clk,    // System clock
    input  wire logic             reset,      // Async reset, active high
    input  wire logic             start,      // Start pulse, ignored while running
    input  wire logic [CNT_W-1:0] load_count, // Cycles to run, at least one
    output logic                  running,    // Delay in progress
    output logic                  done        // Pulse in the last counted cycle
);

    typedef struct packed {
        logic             run;
        logic [CNT_W-1:0] count;
    } dly_state_t;

    dly_state_t state_reg;
    dly_state_t state_next;

    // Run flag and last cycle of a run
    assign running = state_reg.run;
    assign done    = state_reg.run && state_reg.count == CNT_W'(1);

    // Load on start, count down, stop at one
    always_comb begin
        state_next = state_reg;
        if (!state_reg.run) begin
            if (start) begin
                state_next.run   = 1'b1;
                state_next.count = load_count;
            end
        end else if (done) begin
            state_next.run   = 1'b0;
            state_next.count = '0;
        end else begin
            state_next.count = state_reg.count - CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : mpc_delay

// File: verification/mpc_host_model.sv
// Host model issuing indirect interface RAM accesses
`timescale 1ns/1ps
module mpc_host_model
    import mpc_pkg::*;
(
    input  wire logic              sys_clk,          // System clock
    input  wire logic              ram_request_flag, // Access running
    input  wire logic [DATA_W-1:0] access_rdata,     // Read data
    output logic                   access_start,     // Request pulse
    output mpc_req_t               access_req,       // Request fields
    output logic                   timed_out         // A wait ran out
);
    initial begin
        access_start = 1'b0;
        access_req   = '0;
        timed_out    = 1'b0;
    end

    // Waits for a low flag at a settled point, bounded so a hang is seen
    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge sys_clk);
        while (ram_request_flag !== 1'b0 && n < 64) begin
            n++;
            @(negedge sys_clk);
        end
        if (n >= 64) timed_out = 1'b1;
    endtask : wait_idle

    // One whole access; unused config bits always go out as zero
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
        wait_idle();
        @(posedge sys_clk);
        access_start    <= 1'b1;
        access_req.write <= wr;
        access_req.addr  <= a;
        access_req.wdata <= (a == ADDR_PUMP_CONFIGURATION) ? (wd & ~CFG_UNUSED_MASK) : wd;
        @(posedge sys_clk);
        access_start <= 1'b0;
        wait_idle();
        rd = access_rdata;
    endtask : access
endmodule : mpc_host_model

// File: verification/test_mpc_config_map.sv
// Self-checking bench for the configuration word map
`timescale 1ns/1ps
module test_mpc_config_map;
    import mpc_pkg::*;
    localparam logic [8:0] CFG = ADDR_PUMP_CONFIGURATION;
    logic              sys_clk, reset, access_start, ram_request_flag, internal_fault;
    logic              originate_select, manual_handshake_enable, standby_idle;
    logic              pump_error, soft_reset_request, pump_in_reset, timed_out;
    logic [MODE_W-1:0] operating_mode;
    logic [DATA_W-1:0] access_rdata, d;
    mpc_req_t          access_req;
    int                error_cnt, cmp_count;
    logic [8:0]        ta [7] = '{9'h000, 9'h003, 9'h035, 9'h168, 9'h1a6, 9'h1f7, 9'h1fe};
    logic [6:0]        modes [11] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h08,
                                      7'h09, 7'h0b, 7'h10, 7'h11, 7'h13};

    mpc_config_map #(.ACC_CYCLES(8), .SRST_CYCLES(4)) dut (.sys_clk(sys_clk),
        .reset(reset), .access_start(access_start), .access_req(access_req),
        .access_rdata(access_rdata), .ram_request_flag(ram_request_flag),
        .internal_fault(internal_fault), .originate_select(originate_select),
        .manual_handshake_enable(manual_handshake_enable), .operating_mode(operating_mode),
        .standby_idle(standby_idle), .pump_error(pump_error),
        .soft_reset_request(soft_reset_request), .pump_in_reset(pump_in_reset));
    mpc_host_model host (.sys_clk(sys_clk), .ram_request_flag(ram_request_flag),
        .access_rdata(access_rdata), .access_start(access_start),
        .access_req(access_req), .timed_out(timed_out));

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Bus access wrappers; a lost handshake ends the run
    task automatic rd(input logic [8:0] a, output logic [15:0] v);
        host.access(1'b0, a, 16'h0000, v);
        if (timed_out) begin
            error_cnt++;
            test_done();
        end
    endtask : rd

    task automatic wr(input logic [8:0] a, input logic [15:0] v);
        logic [15:0] x;
        host.access(1'b1, a, v, x);
        if (timed_out) begin
            error_cnt++;
            test_done();
        end
    endtask : wr

    // Soft reset by read-modify-write, back to standby, then poll bit 8
    task automatic soft_reset();
        int n;
        rd(CFG, d);
        wr(CFG, (d & ~16'h007f) | 16'h0100);
        check({15'h0, soft_reset_request}, 16'h0001);
        n = 0;
        do begin
            rd(CFG, d);
            n++;
        end while (d[8] !== 1'b0 && n < 8);
        check(d, 16'h0000);
        check({15'h0, pump_error}, 16'h0000);
        check({15'h0, pump_in_reset}, 16'h0000);
    endtask : soft_reset

    initial begin
        sys_clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
    end

    // Watchdog against a stalled sequence
    initial begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        test_done();
    end

    initial begin
        reset = 1'b1;
        internal_fault = 1'b0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        rd(CFG, d);
        check(d, CFG_RESET);
        check({15'h0, standby_idle}, 16'h0001);
        $display("test reset done");
        // Back-to-back writes then reads over range ends; unmapped places read zero
        foreach (ta[i]) wr(ta[i], 16'ha5c3 ^ 16'(ta[i]));
        foreach (ta[i]) begin
            rd(ta[i], d);
            check(d, 16'ha5c3 ^ 16'(ta[i]));
        end
        // Flag must stand in the middle of an access and be gone after it
        fork
            wr(9'h004, 16'hffff);
            begin
                repeat (4) @(negedge sys_clk);
                check({15'h0, ram_request_flag}, 16'h0001);
            end
        join
        check({15'h0, ram_request_flag}, 16'h0000);
        rd(9'h004, d);
        check(d, 16'h0000);
        rd(9'h1a7, d);
        check(d, 16'h0000);
        $display("test words done");
        // Originate, manual handshake and reserved bits in one write with the mode
        wr(CFG, 16'h5e08);
        rd(CFG, d);
        check(d, 16'h5e08);
        check({15'h0, originate_select}, 16'h0001);
        check({15'h0, manual_handshake_enable}, 16'h0001);
        check({9'h0, operating_mode}, 16'h0008);
        check({15'h0, standby_idle}, 16'h0000);
        wr(CFG, 16'h0000);
        check({15'h0, originate_select}, 16'h0000);
        check({15'h0, standby_idle}, 16'h0001);
        $display("test config done");
        // Every legal mode is accepted without error
        foreach (modes[i]) begin
            wr(CFG, 16'h4000 | 16'(modes[i]));
            check({9'h0, operating_mode}, 16'(modes[i]));
            check({15'h0, pump_error}, 16'h0000);
        end
        $display("test modes done");
        // Fault pulse from the core, then recovery by soft reset
        @(posedge sys_clk);
        internal_fault <= 1'b1;
        @(posedge sys_clk);
        internal_fault <= 1'b0;
        @(negedge sys_clk);
        check({15'h0, pump_error}, 16'h0001);
        rd(CFG, d);
        check(d, 16'h6013);
        soft_reset();
        rd(ADDR_TRAINING_CONTROL, d);
        check(d, 16'ha5c3 ^ 16'h01fe);
        // Illegal mode code flags an error
        wr(CFG, 16'h0005);
        // The bad code is only judged once it is stored, so the flag lags a cycle
        @(negedge sys_clk);
        check({15'h0, pump_error}, 16'h0001);
        soft_reset();
        $display("test error done");
        // Hard reset in mid-run clears the map
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd(ADDR_TRAINING_CONTROL, d);
        check(d, WORD_RESET);
        rd(CFG, d);
        check(d, CFG_RESET);
        $display("test hard reset done");
        test_done();
    end
endmodule : test_mpc_config_map
